//--- core/isl_readout.sv
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - sixteen data lanes, one status lane and one forwarded clock lane, sent together
// - forwarded clock is double data rate, half the lane bit rate
// - status lane words have the selected width, aligned with data words
// - each lane sends least significant bit first, bit zero in clock high phase
// - ten bit mode: bit period is one tenth of master clock period
// - twelve bit mode: bit period is one twelfth of master clock period
// - bursts of 128 pixels, one master clock period per pixel
// - one pixel period of overhead between bursts
// - sixteen lane mode: one row in one 128 pixel slot
// - 8, 4, 2 lanes: row lasts k times 128 plus k periods
// - twelve bit mode falls back from sixteen or eight lanes to four lanes, 516 periods per row
// - twelve bit two lane mode: eight bursts and eight overheads per row
// - rows per frame follow a programmable count, default 2048
// - eight lane mode: two bursts per row, even lanes may be disabled
// - four lane mode: lanes 1, 5, 9, 13 unique, four bursts
// - two lane mode: lanes 1 and 9 unique, eight bursts
// - enabled lanes repeat the lowest lane of their group, whether or not that lane is enabled
// - status lane tells the receiver when data lanes hold valid pixels
// - status bits: 0 pixel, 1 row, 2 frame, 9 one, 8/10/11 zero
// - idle status word is 512, all zero but bit nine
// - without a valid pixel, enabled data lanes carry the programmable training word
module isl_readout (
	input wire logic sys_clk_i, // system clock, 250 MHz
	input wire logic rst_i, // async reset, active high
	input wire logic ce_i, // clock enable, freezes all state when low
	input wire logic master_clk_i, // sensor master clock pin
	input wire logic frame_req_i, // one-cycle frame request
	input wire isl_pkg::isl_pix_type pix_data_i, // words of the sixteen source channels
	output logic pix_take_o, // pix_data_i consumed this cycle
	input wire logic [3:0] reg_addr_i, // register address
	input wire logic [15:0] reg_wdata_i, // register write data
	input wire logic reg_wr_i, // register write strobe
	input wire logic reg_rd_i, // register read strobe
	output logic [15:0] reg_rdata_o, // read data, cycle after the strobe
	output logic [31:0] data_ddr_o, // two bits per data lane per cycle
	output logic [1:0] status_ddr_o, // status lane bits
	output logic [1:0] lvds_forwarded_clock_o, // forwarded clock phases
	output logic [15:0] lane_en_o // data lane powered
);
	logic mclk_s1_q;
	logic mclk_s2_q;
	logic mclk_s3_q;
	logic load_q;
	logic pend_q;
	logic pend_d;
	isl_pkg::isl_state_type state_q;
	isl_pkg::isl_state_type state_d;
	logic [6:0] pix_cnt_q;
	logic [6:0] pix_cnt_d;
	logic [2:0] burst_cnt_q;
	logic [2:0] burst_cnt_d;
	logic [11:0] row_cnt_q;
	logic [11:0] row_cnt_d;
	isl_pkg::isl_cfg_type cfg_q;
	logic [11:0] rows_q;
	logic [11:0] train_q;
	logic [15:0] lane_off_q;
	logic [15:0] rdata_q;
	logic [15:0] rdata_d;
	isl_pkg::isl_lanes_type eff_lanes;
	logic [11:0] lane_word [0:15];
	logic [11:0] ser_word [0:17];
	logic [11:0] stat_word;
	logic tick;

	// master clock pin crosses two flops, its rising edge marks a pixel period
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			mclk_s1_q <= 1'b0;
			mclk_s2_q <= 1'b0;
			mclk_s3_q <= 1'b0;
			load_q <= 1'b0;
		end else if (ce_i) begin
			mclk_s1_q <= master_clk_i;
			mclk_s2_q <= mclk_s1_q;
			mclk_s3_q <= mclk_s2_q;
			load_q <= tick;
		end
	end
	// only the settled second flop and its delayed copy feed the edge detector,
	// so a metastable first stage can never reach the sequencer
	assign tick = mclk_s2_q & ~mclk_s3_q;

	// register decode
	wire wr_cfg = reg_wr_i && reg_addr_i == isl_pkg::REG_CFG;
	wire wr_rows = reg_wr_i && reg_addr_i == isl_pkg::REG_ROWS;
	wire wr_train = reg_wr_i && reg_addr_i == isl_pkg::REG_TRAIN;
	wire wr_off = reg_wr_i && reg_addr_i == isl_pkg::REG_LANE_OFF;
	wire [15:0] status_rd = {state_q != isl_pkg::ST_IDLE, 1'b0, row_cnt_q, state_q};

	// register read mux, unmapped addresses read zero
	always_comb begin
		rdata_d = 16'h0000;
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				isl_pkg::REG_CFG: rdata_d = {13'h0000, cfg_q};
				isl_pkg::REG_ROWS: rdata_d = {4'h0, rows_q};
				isl_pkg::REG_TRAIN: rdata_d = {4'h0, train_q};
				isl_pkg::REG_LANE_OFF: rdata_d = lane_off_q;
				isl_pkg::REG_STATUS: rdata_d = status_rd;
				default: rdata_d = 16'h0000;
			endcase
		end
	end

	// software registers
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cfg_q <= isl_pkg::CFG_RST;
			rows_q <= isl_pkg::ROWS_RST;
			train_q <= isl_pkg::TRAIN_RST;
			lane_off_q <= isl_pkg::LANE_OFF_RST;
			rdata_q <= 16'h0000;
		end else if (ce_i) begin
			if (wr_cfg) begin
				cfg_q <= isl_pkg::isl_cfg_type'(reg_wdata_i[2:0]);
			end
			if (wr_rows) begin
				rows_q <= reg_wdata_i[11:0];
			end
			if (wr_train) begin
				train_q <= reg_wdata_i[11:0];
			end
			if (wr_off) begin
				lane_off_q <= reg_wdata_i;
			end
			rdata_q <= rdata_d;
		end
	end
	assign reg_rdata_o = rdata_q;

	// twelve bit words force at most four lanes
	assign eff_lanes = (cfg_q.twelve && (cfg_q.lanes == isl_pkg::LANES_16 || cfg_q.lanes == isl_pkg::LANES_8))
		? isl_pkg::LANES_4 : cfg_q.lanes;
	wire [3:0] grp_mask = 4'((4'h1 << eff_lanes) - 4'h1);
	wire last_burst = burst_cnt_q == grp_mask[2:0];
	wire last_pix = pix_cnt_q == isl_pkg::BURST_LAST;
	wire last_row = ({1'b0, row_cnt_q} + 13'h0001) >= {1'b0, rows_q};
	wire start = tick && pend_q && state_q == isl_pkg::ST_IDLE;
	wire [11:0] wmask = cfg_q.twelve ? isl_pkg::MASK_TWELVE : isl_pkg::MASK_TEN;
	wire pixel_on = state_q == isl_pkg::ST_BURST;
	wire frame_on = state_q != isl_pkg::ST_IDLE;

	// request held until the sequencer is idle at a pixel edge, a new request wins
	// so a pulse landing on the very cycle of the start is never lost
	assign pend_d = frame_req_i | (pend_q & ~start);

	// sequencer: overhead slot, then 128 pixels, k bursts per row
	always_comb begin
		state_d = state_q;
		pix_cnt_d = pix_cnt_q;
		burst_cnt_d = burst_cnt_q;
		row_cnt_d = row_cnt_q;
		if (tick) begin
			unique case (state_q)
				isl_pkg::ST_IDLE: begin
					if (pend_q) begin
						state_d = isl_pkg::ST_OVH;
						burst_cnt_d = 3'h0;
						row_cnt_d = 12'h000;
					end
				end
				isl_pkg::ST_OVH: begin
					state_d = isl_pkg::ST_BURST;
					pix_cnt_d = 7'h00;
				end
				isl_pkg::ST_BURST: begin
					pix_cnt_d = pix_cnt_q + 7'h01;
					if (last_pix) begin
						state_d = isl_pkg::ST_OVH;
						burst_cnt_d = burst_cnt_q + 3'h1;
						if (last_burst) begin
							burst_cnt_d = 3'h0;
							row_cnt_d = row_cnt_q + 12'h001;
							if (last_row) begin
								state_d = isl_pkg::ST_IDLE;
							end
						end
					end
				end
				default: state_d = isl_pkg::ST_IDLE;
			endcase
		end
	end

	// sequencer registers
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q <= isl_pkg::ST_IDLE;
			pend_q <= 1'b0;
			pix_cnt_q <= 7'h00;
			burst_cnt_q <= 3'h0;
			row_cnt_q <= 12'h000;
		end else if (ce_i) begin
			state_q <= state_d;
			pend_q <= pend_d;
			pix_cnt_q <= pix_cnt_d;
			burst_cnt_q <= burst_cnt_d;
			row_cnt_q <= row_cnt_d;
		end
	end

	// pixels are taken as the serializers load a burst period
	assign pix_take_o = load_q && pixel_on;

	// status word of the current pixel period
	always_comb begin
		stat_word = isl_pkg::STAT_IDLE;
		stat_word[isl_pkg::SW_PIXEL] = pixel_on;
		stat_word[isl_pkg::SW_ROW] = frame_on;
		stat_word[isl_pkg::SW_FRAME] = frame_on;
		stat_word[isl_pkg::SW_SLOT] = state_q == isl_pkg::ST_OVH;
		stat_word[isl_pkg::SW_ROW_OH] = state_q == isl_pkg::ST_OVH && burst_cnt_q == 3'h0;
	end

	// per lane source: the lowest lane of its group, training word outside pixels
	for (genvar l = 0; l < isl_pkg::LANES; l++) begin : g_lane
		localparam logic [3:0] LN = 4'(l);
		wire [3:0] src = LN & ~grp_mask;
		wire [11:0] pick = pixel_on ? pix_data_i[src] : train_q;
		assign lane_word[l] = lane_off_q[l] ? 12'h000 : (pick & wmask);
		assign lane_en_o[l] = ~lane_off_q[l];
		assign ser_word[l] = lane_word[l];
	end
	assign ser_word[isl_pkg::STATUS_SER] = stat_word & wmask;
	assign ser_word[isl_pkg::CLOCK_SER] = isl_pkg::CLK_PATTERN;

	// all lanes load together at each pixel period start
	for (genvar s = 0; s < isl_pkg::SER_NUM; s++) begin : g_ser
		wire [1:0] ddr;
		isl_lane_ser u_ser (
			.sys_clk_i(sys_clk_i),
			.rst_i(rst_i),
			.ce_i(ce_i),
			.load_i(load_q),
			.twelve_i(cfg_q.twelve),
			.word_i(ser_word[s]),
			.ddr_o(ddr)
		);
		if (s < isl_pkg::LANES) begin : g_data
			assign data_ddr_o[2*s+1:2*s] = ddr;
		end else if (s == isl_pkg::STATUS_SER) begin : g_stat
			assign status_ddr_o = ddr;
		end else begin : g_clk
			assign lvds_forwarded_clock_o = ddr;
		end
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	status_const_a: assert property (stat_word[11:8] == 4'h2)
		else $error("status constant bits wrong");
	idle_word_a: assert property (state_q == isl_pkg::ST_IDLE |-> stat_word == isl_pkg::STAT_IDLE)
		else $error("idle status word is not 512");
	train_fill_a: assert property (!pixel_on && !lane_off_q[0] |-> lane_word[0] == (train_q & wmask))
		else $error("training word missing outside pixels");
	overhead_one_a: assert property (tick && ce_i && state_q == isl_pkg::ST_OVH |=> pixel_on)
		else $error("overhead slot longer than one pixel");
	burst_end_a: assert property (tick && ce_i && pixel_on && last_pix |=> !pixel_on)
		else $error("burst longer than 128 pixels");
	twelve_fall_a: assert property (cfg_q.twelve && cfg_q.lanes == isl_pkg::LANES_16
		|-> eff_lanes == isl_pkg::LANES_4)
		else $error("twelve bit mode not on four lanes");
	dup_lane_a: assert property (eff_lanes != isl_pkg::LANES_16 && lane_off_q[1:0] == 2'b00
		|-> lane_word[1] == lane_word[0])
		else $error("lane two does not repeat lane one");
	two_lane_a: assert property (eff_lanes == isl_pkg::LANES_2 && lane_off_q[15:8] == 8'h00
		|-> lane_word[15] == lane_word[8])
		else $error("lane sixteen does not repeat lane nine");
	four_src_a: assert property (eff_lanes == isl_pkg::LANES_4 && pixel_on && !lane_off_q[4]
		|-> lane_word[4] == (pix_data_i[4] & wmask))
		else $error("lane five lost its own channel");
	frame_end_a: assert property (tick && ce_i && pixel_on && last_pix && last_burst && last_row
		|=> state_q == isl_pkg::ST_IDLE)
		else $error("frame did not end after the last row");


	// lane disable bits silence a lane whatever the mode
	for (genvar q = 0; q < isl_pkg::LANES; q++) begin : g_chk
		lane_quiet_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
			lane_off_q[q] |-> lane_word[q] == 12'h000)
			else $error("disabled lane still carries a word");
	end

	// valid pixels always sit inside a valid row and frame
	row_frame_a: assert property (pixel_on |-> stat_word[isl_pkg::SW_ROW] && stat_word[isl_pkg::SW_FRAME])
		else $error("pixel flag outside row or frame");

	// ten bit words keep the two top status bits clear on the wire
	ten_width_a: assert property (!cfg_q.twelve |-> ser_word[isl_pkg::STATUS_SER][11:10] == 2'b00)
		else $error("status word wider than ten bits");

	// eight lane mode: odd lanes send their own channel
	eight_src_a: assert property (eff_lanes == isl_pkg::LANES_8 && pixel_on && !lane_off_q[2]
		|-> lane_word[2] == (pix_data_i[2] & wmask))
		else $error("lane three lost its own channel");

	// one take pulse per burst pixel period, never two cycles in a row
	take_pulse_a: assert property (pix_take_o |=> !pix_take_o)
		else $error("pixel take longer than one cycle");

	// sixteen lane rows never need a second burst
	one_burst_a: assert property (eff_lanes == isl_pkg::LANES_16 |-> burst_cnt_q == 3'h0)
		else $error("sixteen lane row used a second burst");

	// burst counter stays inside the row for the active lane count
	burst_range_a: assert property (burst_cnt_q <= grp_mask[2:0])
		else $error("burst counter past the last burst of a row");

	// a request met at a pixel edge opens with an overhead slot
	start_ovh_a: assert property (start && ce_i |=> state_q == isl_pkg::ST_OVH)
		else $error("frame did not open with an overhead slot");

	// twelve bit two lane rows keep their eight bursts
	twelve_two_a: assert property (cfg_q.twelve && cfg_q.lanes == isl_pkg::LANES_2
		|-> eff_lanes == isl_pkg::LANES_2)
		else $error("twelve bit two lane mode lost");

	// overhead slots carry no pixel and raise the slot flag
	slot_flag_a: assert property (state_q == isl_pkg::ST_OVH
		|-> stat_word[isl_pkg::SW_SLOT] && !stat_word[isl_pkg::SW_PIXEL])
		else $error("overhead slot flags wrong");

	// the first overhead slot of a row also raises the row overhead flag
	row_oh_a: assert property (state_q == isl_pkg::ST_OVH && burst_cnt_q == 3'h0
		|-> stat_word[isl_pkg::SW_ROW_OH])
		else $error("row overhead flag missing");

	frame_start_c: cover property (start && ce_i);
	eight_lane_c: cover property (eff_lanes == isl_pkg::LANES_8 && pixel_on && last_pix && last_burst);
	lane_off_c: cover property (lane_off_q != 16'h0000 && pixel_on);
	twelve_row_c: cover property (cfg_q.twelve && pixel_on && last_pix && last_burst && tick);
	two_lane_c: cover property (eff_lanes == isl_pkg::LANES_2 && burst_cnt_q == 3'h7 && pixel_on);
endmodule
`default_nettype wire

//--- core/isl_pkg.sv
package isl_pkg;
	// lane structure
	localparam int LANES = 16;
	localparam int WORD_W = 12;
	localparam int SER_NUM = 18;
	localparam int STATUS_SER = 16;
	localparam int CLOCK_SER = 17;
	// register offsets on the plain register port
	localparam logic [3:0] REG_CFG = 4'h0;
	localparam logic [3:0] REG_ROWS = 4'h1;
	localparam logic [3:0] REG_TRAIN = 4'h2;
	localparam logic [3:0] REG_LANE_OFF = 4'h3;
	localparam logic [3:0] REG_STATUS = 4'h4;
	// field positions
	localparam int CFG_LANES_LSB = 0;
	localparam int CFG_TWELVE_BIT = 2;
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_ROW_LSB = 2;
	localparam int STAT_FRAME_BIT = 15;
	localparam int SW_PIXEL = 0;
	localparam int SW_ROW = 1;
	localparam int SW_FRAME = 2;
	localparam int SW_SLOT = 3;
	localparam int SW_ROW_OH = 4;
	localparam int SW_ONE = 9;
	// values after reset
	localparam logic [11:0] ROWS_RST = 12'h800;
	localparam logic [11:0] TRAIN_RST = 12'h3A5;
	localparam logic [15:0] LANE_OFF_RST = 16'h0000;
	// fixed words and counts
	localparam logic [6:0] BURST_LAST = 7'h7F;
	localparam logic [11:0] STAT_IDLE = 12'h200;
	localparam logic [11:0] MASK_TEN = 12'h3FF;
	localparam logic [11:0] MASK_TWELVE = 12'hFFF;
	localparam logic [11:0] CLK_PATTERN = 12'h555;
	localparam logic [2:0] PAIRS_TEN = 3'h5;
	localparam logic [2:0] PAIRS_TWELVE = 3'h6;
	// row multiplexing modes
	typedef enum logic [1:0] {
		LANES_16 = 2'b00,
		LANES_8 = 2'b01,
		LANES_4 = 2'b10,
		LANES_2 = 2'b11
	} isl_lanes_type;
	// readout sequencer states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_OVH = 2'b01,
		ST_BURST = 2'b10
	} isl_state_type;
	typedef struct packed {
		logic twelve;
		isl_lanes_type lanes;
	} isl_cfg_type;
	localparam isl_cfg_type CFG_RST = '{twelve: 1'b0, lanes: LANES_16};
	// one pixel word per source channel, channel one lowest
	typedef logic [15:0][11:0] isl_pix_type;
endpackage

//--- core/isl_lane_ser.sv
`timescale 1ns/1ns
`default_nettype none
module isl_lane_ser (
	input wire logic sys_clk_i, // system clock
	input wire logic rst_i, // async reset, active high
	input wire logic ce_i, // clock enable
	input wire logic load_i, // start of a pixel period
	input wire logic twelve_i, // twelve bit words
	input wire logic [11:0] word_i, // word to send
	output logic [1:0] ddr_o // [0] high phase bit, [1] low phase bit
);
	logic [11:0] sh_q;
	logic [2:0] left_q;
	logic [1:0] ddr_q;
	wire [2:0] pairs = twelve_i ? isl_pkg::PAIRS_TWELVE : isl_pkg::PAIRS_TEN;
	wire [1:0] word_low = word_i[1:0];

	// shift two bits per cycle, low bit first, silent after the word
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sh_q <= 12'h000;
			left_q <= 3'h0;
			ddr_q <= 2'h0;
		end else if (ce_i) begin
			if (load_i) begin
				ddr_q <= word_i[1:0];
				sh_q <= {2'h0, word_i[11:2]};
				left_q <= pairs - 3'h1;
			end else if (left_q != 3'h0) begin
				ddr_q <= sh_q[1:0];
				sh_q <= {2'h0, sh_q[11:2]};
				left_q <= left_q - 3'h1;
			end else begin
				ddr_q <= 2'h0;
			end
		end
	end
	assign ddr_o = ddr_q;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	lsb_first_a: assert property (load_i && ce_i |=> ddr_o == $past(word_low))
		else $error("first pair is not the low bits of the word");
	word_len_a: assert property (load_i && ce_i && !twelve_i |=> left_q == 3'h4)
		else $error("ten bit word pair count wrong");
endmodule
`default_nettype wire

//--- test/isl_rx_model.sv
`timescale 1ns/1ns
`default_nettype none
// receiving deserializer: frames words on the forwarded clock pattern
module isl_rx_model (
	input wire logic sys_clk_i, // system clock
	input wire logic rst_i, // async reset, active high
	input wire logic [31:0] data_ddr_i, // data lane pairs
	input wire logic [1:0] status_ddr_i, // status lane pair
	input wire logic [1:0] fwd_clk_i, // forwarded clock phases
	output isl_pkg::isl_pix_type lane_word_o, // last word per lane
	output logic [11:0] stat_word_o, // last status word
	output logic [3:0] pairs_o, // pairs in last word
	output logic word_ok_o // one-cycle word strobe
);
	isl_pkg::isl_pix_type sh_q;
	logic [11:0] ssh_q;
	logic [3:0] n_q;
	// bits taken on both clock phases, word ends when the clock stops
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sh_q <= '0;
			ssh_q <= 12'h000;
			n_q <= 4'h0;
			lane_word_o <= '0;
			stat_word_o <= 12'h000;
			pairs_o <= 4'h0;
			word_ok_o <= 1'b0;
		end else begin
			word_ok_o <= 1'b0;
			if (fwd_clk_i == 2'b01) begin
				for (int l = 0; l < 16; l++) begin
					sh_q[l][2 * n_q +: 2] <= data_ddr_i[2 * l +: 2];
				end
				ssh_q[2 * n_q +: 2] <= status_ddr_i;
				n_q <= n_q + 4'h1;
			end else if (n_q != 4'h0) begin
				lane_word_o <= sh_q;
				stat_word_o <= ssh_q;
				pairs_o <= n_q;
				word_ok_o <= 1'b1;
				n_q <= 4'h0;
				sh_q <= '0;
				ssh_q <= 12'h000;
			end
		end
	end
endmodule
`default_nettype wire

//--- test/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module tb_top;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic master_clk = 1'b0;
	logic frame_req = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	isl_pkg::isl_pix_type pix;
	logic pix_take;
	logic [15:0] reg_rdata;
	logic [31:0] data_ddr;
	logic [1:0] status_ddr;
	logic [1:0] fwd_clk;
	logic [15:0] lane_en;
	isl_pkg::isl_pix_type rx_word;
	logic [11:0] rx_stat;
	logic [3:0] rx_pairs;
	logic rx_ok;
	logic [11:0] train_exp = isl_pkg::TRAIN_RST;
	int err_count = 0;
	int check_count = 0;
	int take_cnt = 0;
	// clocks: 4 ns system, free-running 32 ns master clock off the grid
	always #2 sys_clk = ~sys_clk;
	initial begin
		#1;
		forever #16 master_clk = ~master_clk;
	end
	initial begin
		for (int i = 0; i < 16; i++) pix[i] = 12'(12'h8C1 + 12'h045 * i);
	end
	always @(posedge sys_clk) if (pix_take) take_cnt++;
	isl_readout u_dut (.sys_clk_i(sys_clk), .rst_i(rst), .ce_i(1'b1), .master_clk_i(master_clk),
		.frame_req_i(frame_req), .pix_data_i(pix), .pix_take_o(pix_take), .reg_addr_i(reg_addr),
		.reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
		.data_ddr_o(data_ddr), .status_ddr_o(status_ddr), .lvds_forwarded_clock_o(fwd_clk), .lane_en_o(lane_en));
	isl_rx_model u_rx (.sys_clk_i(sys_clk), .rst_i(rst), .data_ddr_i(data_ddr), .status_ddr_i(status_ddr),
		.fwd_clk_i(fwd_clk), .lane_word_o(rx_word), .stat_word_o(rx_stat), .pairs_o(rx_pairs), .word_ok_o(rx_ok));
	// verdict and end of run
	task automatic stop_test;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// register bus cycles
	task automatic reg_wr_t(input logic [3:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic reg_rd_t(input logic [3:0] a, output logic [15:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
		@(posedge sys_clk);
	endtask
	task automatic wait_word;
		for (int i = 0; i < 100; i++) begin
			@(posedge sys_clk);
			if (rx_ok) return;
		end
		err_count++;
		stop_test;
	endtask
	// one frame: counts status flags and checks every lane word
	task automatic run_frame(input logic [2:0] cfg, input logic [11:0] rows, input logic [15:0] off, input int k,
		input logic [11:0] mask, input logic [3:0] pairs);
		int rv, pv, oh, rs, bad, start;
		logic done;
		logic [11:0] ex;
		rv = 0; pv = 0; oh = 0; rs = 0; bad = 0; done = 1'b0;
		reg_wr_t(isl_pkg::REG_CFG, {13'h0000, cfg});
		reg_wr_t(isl_pkg::REG_ROWS, {4'h0, rows});
		reg_wr_t(isl_pkg::REG_LANE_OFF, off);
		`CHK(lane_en, ~off)
		wait_word;
		wait_word;
		start = take_cnt;
		frame_req <= 1'b1;
		@(posedge sys_clk);
		frame_req <= 1'b0;
		for (int i = 0; i < 20000 && !done; i++) begin
			@(posedge sys_clk);
			if (rx_ok) begin
				rv += rx_stat[1];
				pv += rx_stat[0];
				oh += rx_stat[3];
				rs += rx_stat[4];
				if (rx_stat[11:8] !== 4'h2 || rx_pairs !== pairs || (rx_stat[0] && rx_stat[2:1] !== 2'b11)) bad++;
				for (int l = 0; l < 16; l++) begin
					ex = off[l] ? 12'h000 : (rx_stat[0] ? pix[l & ~(k - 1)] : train_exp) & mask;
					if (rx_word[l] !== ex) bad++;
				end
				done = (rv > 0 && !rx_stat[1]);
			end
		end
		if (!done) begin
			err_count++;
			stop_test;
		end
		`CHK(rx_stat, isl_pkg::STAT_IDLE)
		`CHK(rv, rows * k * 129)
		`CHK(pv, rows * k * 128)
		`CHK(oh, rows * k)
		`CHK(rs, int'(rows))
		`CHK(take_cnt - start, rows * k * 128)
		`CHK(bad, 0)
	endtask
	task automatic t_reset;
		logic [15:0] d;
		reg_rd_t(isl_pkg::REG_CFG, d);
		`CHK(d, 16'h0000)
		reg_rd_t(isl_pkg::REG_ROWS, d);
		`CHK(d[11:0], 12'h800)
		reg_rd_t(isl_pkg::REG_TRAIN, d);
		`CHK(d[11:0], isl_pkg::TRAIN_RST)
		reg_rd_t(isl_pkg::REG_LANE_OFF, d);
		`CHK(d, 16'h0000)
		`CHK(lane_en, 16'hFFFF)
		reg_rd_t(isl_pkg::REG_STATUS, d);
		`CHK(d[1:0], 2'h0)
		reg_rd_t(4'hF, d);
		`CHK(d, 16'h0000)
		wait_word;
		`CHK(rx_stat, 12'h200)
		`CHK(rx_pairs, 4'h5)
		`CHK(rx_word[15], isl_pkg::TRAIN_RST & isl_pkg::MASK_TEN)
		$display("test reset done");
	endtask
	task automatic t_modes;
		for (int m = 0; m < 4; m++) begin
			run_frame({1'b0, 2'(m)}, 12'h001, (m == 1) ? 16'hAAAA : 16'h0000, 1 << m, isl_pkg::MASK_TEN, 4'h5);
		end
		$display("test ten bit modes done");
	endtask
	task automatic t_twelve;
		run_frame(3'b100, 12'h001, 16'h0000, 4, isl_pkg::MASK_TWELVE, 4'h6);
		run_frame(3'b111, 12'h001, 16'h0000, 8, isl_pkg::MASK_TWELVE, 4'h6);
		$display("test twelve bit modes done");
	endtask
	task automatic t_rows_train;
		reg_wr_t(isl_pkg::REG_TRAIN, 16'h0C3A);
		train_exp = 12'hC3A;
		run_frame(3'b000, 12'h002, 16'h0000, 1, isl_pkg::MASK_TEN, 4'h5);
		$display("test rows and training done");
	endtask
	// main sequence
	initial begin
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		t_reset;
		t_modes;
		t_twelve;
		t_rows_train;
		stop_test;
	end
endmodule
`default_nettype wire
